// ===== design/fcp_pkg.sv
// ----------------------------------------------------------------------------
// shared constants of the coprocessor host-bus port
// ----------------------------------------------------------------------------
package fcp_pkg;

  // bus widths
  localparam int ADDR_HI     = 31;
  localparam int ADDR_LO     = 2;
  localparam int DATA_W      = 32;
  localparam int BE_W        = 3;

  // window decode: top seven word-address bits plus the memory indicator
  localparam int WIN_HI      = 31;
  localparam int WIN_LO      = 25;
  localparam logic [6:0] WIN_TAG = 7'h60;  // c0000000 .. c1ffffff

  // operation code: word-address bits 15..2 and three byte lanes
  localparam int OP_HI       = 15;
  localparam int OP_ADDR_W   = 14;
  localparam int OP_W        = OP_ADDR_W + BE_W;

  // wait cycles before ready, standard bus and three-cycle bus
  localparam logic [1:0] WAIT_STD  = 2'h1;
  localparam logic [1:0] WAIT_TCB  = 2'h2;

  // idle levels of the active-low pins and the data bus
  localparam logic       NEG_IDLE  = 1'b1;
  localparam logic [DATA_W-1:0] DATA_IDLE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_PULL = 32'hFFFF_FFFF;

  typedef logic [ADDR_HI:ADDR_LO] fcp_addr_t;
  typedef logic [OP_W-1:0]        fcp_op_t;

  // true when a memory access falls in the coprocessor window
  function automatic logic fcp_win_hit(input fcp_addr_t addr, input logic mem_io);
    return mem_io && (addr[WIN_HI:WIN_LO] == WIN_TAG);
  endfunction

endpackage

// ===== design/fcp_bus_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// host local bus between host end and coprocessor end
// ----------------------------------------------------------------------------
interface fcp_bus_if;
  logic                          bus_reset;
  logic                          address_strobe_n;
  logic                          mem_io;
  logic                          write_read;
  fcp_pkg::fcp_addr_t            word_address;
  logic [fcp_pkg::BE_W-1:0]      byte_lane_enables_n;
  logic [fcp_pkg::DATA_W-1:0]    host_data;
  logic                          host_data_oe;
  logic [fcp_pkg::DATA_W-1:0]    dev_data;
  logic                          dev_data_oe;
  logic [fcp_pkg::DATA_W-1:0]    data;
  logic                          sys_ready_n;
  logic                          dev_ready_n;
  logic                          dev_ready_oe;
  logic                          ready_n;
  logic                          copro_select_n;
  logic                          three_cycle_strap_n;
  logic                          chipset_aux_out_n;
  logic                          chipset_aux_oe;
  logic                          chipset_aux;

  // shared data wire, pulled high when nobody drives it
  assign data = dev_data_oe ? dev_data : (host_data_oe ? host_data : fcp_pkg::DATA_PULL);

  // transfer acknowledge: plain gating, no register in the path
  assign ready_n = sys_ready_n & (dev_ready_oe ? dev_ready_n : fcp_pkg::NEG_IDLE);

  // aux line is pulled up when released
  assign chipset_aux = chipset_aux_oe ? chipset_aux_out_n : fcp_pkg::NEG_IDLE;

  modport dev (
    input  bus_reset, address_strobe_n, mem_io, write_read, word_address,
           byte_lane_enables_n, data, ready_n, three_cycle_strap_n,
    output dev_data, dev_data_oe, dev_ready_n, dev_ready_oe, copro_select_n,
           chipset_aux_out_n, chipset_aux_oe
  );

  modport host (
    input  data, ready_n, copro_select_n, chipset_aux,
    output bus_reset, address_strobe_n, mem_io, write_read, word_address,
           byte_lane_enables_n, host_data, host_data_oe, sys_ready_n,
           three_cycle_strap_n
  );
endinterface

// ===== design/fcp_dev_port.sv
`timescale 1ns/1ps
// Behaviour
// - all timing taken from the one double-rate clock
// - system feeds host's double-rate clock, dedicated trace
// - coprocessor looks like memory; ops are moves
// - reset asserted and released with host clock
// - ready merged into acknowledge by gating only
// - select low while address hits, combinationally
// - select may float or gate other drivers
// - select may drop early under pipelined addressing
// - three-cycle strap input; open means standard bus
// - auxiliary active-low output for chipset systems
// - word address, three byte lanes, full data bus
// - strobe, memory, write, acknowledge, reset are sampled
// - decode top seven bits with memory indicator
// - opcode from address 15..2 and byte lanes
// - write starts operation; read drives data bus
module fcp_dev_port (
  input  wire logic                         i_clk,
  input  wire logic                         i_nrst,
  fcp_bus_if.dev                            bus,
  input  wire logic                         i_core_ready,
  input  wire logic [fcp_pkg::DATA_W-1:0]   i_rd_data,
  output logic                              o_op_valid,
  output logic                              o_op_write,
  output fcp_pkg::fcp_op_t                  o_op_code,
  output logic [fcp_pkg::DATA_W-1:0]        o_op_data,
  output logic                              o_chipset_mode
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_ACK  = 3'b100
  } fcp_dev_state_t;

  fcp_dev_state_t                 state_q;
  logic [1:0]                     wait_q;
  logic                           write_q;
  fcp_pkg::fcp_op_t               op_q;
  logic                           strap_taken_q;
  logic                           tcb_q;
  logic                           start;
  logic                           hit;
  logic                           wait_done;

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  // select follows the address bus with no register, so under pipelined
  // addressing it may already show the next address before this cycle ends
  assign hit = fcp_pkg::fcp_win_hit(bus.word_address, bus.mem_io);
  assign bus.copro_select_n = ~hit;

  // a cycle starts on a sampled strobe into the window
  assign start = (state_q == ST_IDLE) && !bus.address_strobe_n && hit
                 && !bus.bus_reset;

  // a write waits for the engine to accept; a read for the result
  assign wait_done = (wait_q == 2'h0) && i_core_ready;

  // --------------------------------------------------------------------------
  // strap capture
  // --------------------------------------------------------------------------
  // the strap is a level, caught by the first clock after reset release and by every clock that samples bus reset high, never by
  // the reset itself; an open pin reads high and selects the standard bus
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      strap_taken_q <= 1'b0;
      tcb_q         <= 1'b0;
    end else if (!strap_taken_q || bus.bus_reset) begin
      strap_taken_q <= 1'b1;
      tcb_q         <= ~bus.three_cycle_strap_n;
    end
  end

  // --------------------------------------------------------------------------
  // cycle sequencer
  // --------------------------------------------------------------------------
  // host reset is sampled like any other bus input and clears the cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
    end else if (bus.bus_reset) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wait_done) begin
            state_q <= ST_ACK;
          end
        end
        ST_ACK: begin
          // the cycle ends on the merged acknowledge, not on our own ready
          if (!bus.ready_n) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // wait counter; the three-cycle bus gets one extra cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_q <= 2'h0;
    end else if (start) begin
      wait_q <= tcb_q ? fcp_pkg::WAIT_TCB : fcp_pkg::WAIT_STD;
    end else if (state_q == ST_WAIT && wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end
  end

  // opcode and direction are latched at the strobe; the address may move on
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      op_q    <= '0;
      write_q <= 1'b0;
    end else if (start) begin
      op_q    <= {bus.word_address[fcp_pkg::OP_HI:fcp_pkg::ADDR_LO],
                  bus.byte_lane_enables_n};
      write_q <= bus.write_read;
    end
  end

  // --------------------------------------------------------------------------
  // bus drive
  // --------------------------------------------------------------------------
  // ready and data are driven only while acknowledging a selected cycle,
  // released the edge the merged acknowledge is seen
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus.dev_ready_n  <= fcp_pkg::NEG_IDLE;
      bus.dev_ready_oe <= 1'b0;
    end else if (bus.bus_reset || state_q == ST_ACK && !bus.ready_n) begin
      bus.dev_ready_n  <= fcp_pkg::NEG_IDLE;
      bus.dev_ready_oe <= 1'b0;
    end else if (state_q == ST_WAIT && wait_done) begin
      bus.dev_ready_n  <= 1'b0;
      bus.dev_ready_oe <= 1'b1;
    end
  end

  // read data comes from the engine at the same edge ready goes low
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus.dev_data    <= fcp_pkg::DATA_IDLE;
      bus.dev_data_oe <= 1'b0;
    end else if (bus.bus_reset || state_q == ST_ACK && !bus.ready_n) begin
      bus.dev_data    <= fcp_pkg::DATA_IDLE;
      bus.dev_data_oe <= 1'b0;
    end else if (state_q == ST_WAIT && wait_done && !write_q) begin
      bus.dev_data    <= i_rd_data;
      bus.dev_data_oe <= 1'b1;
    end
  end

  // aux line only answers in chipset mode, during a selected cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus.chipset_aux_out_n <= fcp_pkg::NEG_IDLE;
      bus.chipset_aux_oe    <= 1'b0;
    end else if (bus.bus_reset || state_q == ST_ACK && !bus.ready_n) begin
      bus.chipset_aux_out_n <= fcp_pkg::NEG_IDLE;
      bus.chipset_aux_oe    <= 1'b0;
    end else if (start && tcb_q) begin
      bus.chipset_aux_out_n <= 1'b0;
      bus.chipset_aux_oe    <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // engine side
  // --------------------------------------------------------------------------
  // a write hands its opcode and data to the engine as a one-cycle pulse;
  // a read also pulses so the engine can advance its result pointer
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_op_valid <= 1'b0;
      o_op_write <= 1'b0;
      o_op_code  <= '0;
      o_op_data  <= fcp_pkg::DATA_IDLE;
    end else begin
      o_op_valid <= (state_q == ST_ACK) && !bus.ready_n && !bus.bus_reset;
      if (state_q == ST_ACK && !bus.ready_n) begin
        o_op_write <= write_q;
        o_op_code  <= op_q;
        o_op_data  <= write_q ? bus.data : fcp_pkg::DATA_IDLE;
      end
    end
  end

  // strap mode shown to the engine
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_chipset_mode <= 1'b0;
    end else begin
      o_chipset_mode <= tcb_q;
    end
  end

endmodule // fcp_dev_port

// ===== design/fcp_host_port.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// host end: runs one bus cycle per request on the shared double-rate clock
// ----------------------------------------------------------------------------
module fcp_host_port (
  input  wire logic                         i_clk,
  input  wire logic                         i_nrst,
  fcp_bus_if.host                           bus,
  input  wire logic                         i_sys_reset,
  input  wire logic                         i_chipset_mode,
  input  wire logic                         i_sys_ready_n,
  input  wire logic                         i_req,
  input  wire logic                         i_req_write,
  input  wire fcp_pkg::fcp_addr_t           i_req_addr,
  input  wire logic [fcp_pkg::BE_W-1:0]     i_req_be_n,
  input  wire logic [fcp_pkg::DATA_W-1:0]   i_req_wdata,
  output logic                              o_busy,
  output logic                              o_done,
  output logic [fcp_pkg::DATA_W-1:0]        o_rdata,
  output logic                              o_select_seen,
  output logic                              o_chipset_aux_n
);

  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_CYC  = 2'b10
  } fcp_host_state_t;

  fcp_host_state_t state_q;

  // --------------------------------------------------------------------------
  // reset, strap and local ready are system wiring, driven from flops
  // --------------------------------------------------------------------------
  // reset is re-timed so it rises and falls with the bus clock
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus.bus_reset           <= 1'b1;
      bus.three_cycle_strap_n <= fcp_pkg::NEG_IDLE;
      bus.sys_ready_n         <= fcp_pkg::NEG_IDLE;
    end else begin
      bus.bus_reset           <= i_sys_reset;
      bus.three_cycle_strap_n <= ~i_chipset_mode;
      bus.sys_ready_n         <= i_sys_ready_n;
    end
  end

  // --------------------------------------------------------------------------
  // cycle sequencer: one strobe cycle, then wait for the merged acknowledge
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= HS_IDLE;
    end else if (bus.bus_reset) begin
      state_q <= HS_IDLE;
    end else begin
      case (state_q)
        HS_IDLE: begin
          if (i_req) begin
            state_q <= HS_CYC;
          end
        end
        HS_CYC: begin
          if (!bus.address_strobe_n == 1'b0 && !bus.ready_n) begin
            state_q <= HS_IDLE;
          end
        end
        default: begin
          state_q <= HS_IDLE;
        end
      endcase
    end
  end

  // address phase: strobe low for exactly one cycle, address held to the end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus.address_strobe_n    <= fcp_pkg::NEG_IDLE;
      bus.mem_io              <= 1'b0;
      bus.write_read          <= 1'b0;
      bus.word_address        <= '0;
      bus.byte_lane_enables_n <= '1;
    end else if (state_q == HS_IDLE && i_req && !bus.bus_reset) begin
      bus.address_strobe_n    <= 1'b0;
      bus.mem_io              <= 1'b1;
      bus.write_read          <= i_req_write;
      bus.word_address        <= i_req_addr;
      bus.byte_lane_enables_n <= i_req_be_n;
    end else begin
      bus.address_strobe_n    <= fcp_pkg::NEG_IDLE;
    end
  end

  // write data stands on the bus for the whole write cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus.host_data    <= fcp_pkg::DATA_IDLE;
      bus.host_data_oe <= 1'b0;
    end else if (state_q == HS_IDLE && i_req && !bus.bus_reset) begin
      bus.host_data    <= i_req_wdata;
      bus.host_data_oe <= i_req_write;
    end else if (state_q == HS_CYC && !bus.address_strobe_n == 1'b0 && !bus.ready_n) begin
      bus.host_data_oe <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // user answer
  // --------------------------------------------------------------------------
  // select is only reported; nothing here depends on it lasting the cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy          <= 1'b0;
      o_done          <= 1'b0;
      o_rdata         <= fcp_pkg::DATA_IDLE;
      o_select_seen   <= 1'b0;
      o_chipset_aux_n <= fcp_pkg::NEG_IDLE;
    end else begin
      o_done          <= (state_q == HS_CYC) && bus.address_strobe_n && !bus.ready_n && !bus.bus_reset;
      o_busy          <= (state_q == HS_CYC) ? !(bus.address_strobe_n && !bus.ready_n) : (i_req && !bus.bus_reset);
      o_select_seen   <= ~bus.copro_select_n;
      o_chipset_aux_n <= bus.chipset_aux;
      if (state_q == HS_CYC && bus.address_strobe_n && !bus.ready_n && !bus.write_read) begin
        o_rdata <= bus.data;
      end
    end
  end

endmodule // fcp_host_port

// ===== bench/fcp_bus_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// bus checker: watches the shared host bus between host end and device end
// ----------------------------------------------------------------------------
module fcp_bus_checker (
  input wire logic               i_clk,
  input wire logic               i_nrst,
  input wire logic               bus_reset,
  input wire logic               address_strobe_n,
  input wire logic               mem_io,
  input wire logic               write_read,
  input wire fcp_pkg::fcp_addr_t word_address,
  input wire logic               host_data_oe,
  input wire logic               dev_data_oe,
  input wire logic               sys_ready_n,
  input wire logic               dev_ready_n,
  input wire logic               dev_ready_oe,
  input wire logic               ready_n,
  input wire logic               copro_select_n,
  input wire logic               three_cycle_strap_n,
  input wire logic               chipset_aux_out_n,
  input wire logic               chipset_aux_oe
);
  logic win_hit;

  // window worked out here from the address range, not from the package helper
  assign win_hit = mem_io && (word_address[31:25] == 7'h60);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_select_decode: assert property (copro_select_n == !win_hit)
    else $error("select does not follow the window decode");
  a_ready_standard: assert property (
    (!address_strobe_n && win_hit && !bus_reset && three_cycle_strap_n)
      |=> !dev_ready_oe [*2] ##[1:40] (dev_ready_oe && !dev_ready_n))
    else $error("standard bus ready out of place");
  a_ready_three_cycle: assert property (
    (!address_strobe_n && win_hit && !bus_reset && !three_cycle_strap_n)
      |=> !dev_ready_oe [*3] ##[1:40] (dev_ready_oe && !dev_ready_n))
    else $error("three-cycle bus ready out of place");
  a_miss_ignored: assert property ((!address_strobe_n && !win_hit) |=> !dev_ready_oe [*6])
    else $error("device answered outside its window");
  a_ready_release: assert property ((dev_ready_oe && !ready_n) |=> !dev_ready_oe && !dev_data_oe)
    else $error("device drive held past the acknowledge");
  a_read_drive: assert property (dev_data_oe |-> dev_ready_oe && !write_read)
    else $error("data driven outside a read answer");
  a_ready_merge: assert property (ready_n == (sys_ready_n & (dev_ready_oe ? dev_ready_n : 1'b1)))
    else $error("merged acknowledge is not plain gating");
  a_no_contention: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data bus");
  a_aux_gate: assert property (chipset_aux_oe |-> !three_cycle_strap_n && !chipset_aux_out_n)
    else $error("aux output driven in standard mode");
  a_bus_reset: assert property (bus_reset |=> !dev_ready_oe && !dev_data_oe && !chipset_aux_oe)
    else $error("device drives while bus reset is high");

  // main traffic kinds seen at least once
  c_write_hit: cover property (!address_strobe_n && win_hit && write_read);
  c_read_drive: cover property (dev_data_oe && !ready_n);
  c_aux_low: cover property (chipset_aux_oe && !chipset_aux_out_n);
  c_miss: cover property (!address_strobe_n && !win_hit);
endmodule // fcp_bus_checker

// ===== bench/tb_fp_coprocessor_host_bus_port.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error at %0t: mismatch got %0h expected %0h", $time, (got), (exp)); end end
// ----------------------------------------------------------------------------
// bench top: host end and device end joined by the shared bus
// ----------------------------------------------------------------------------
module tb_fp_coprocessor_host_bus_port;
  logic             i_clk, i_nrst, core_ready, sys_reset, chipset_mode, sys_ready_n;
  logic             req, req_write, op_valid, op_write, dev_chipset_mode;
  logic             busy, done, select_seen, aux_n;
  logic [31:0]      rd_data, req_wdata, op_data, rdata;
  logic [2:0]       req_be_n;
  fcp_pkg::fcp_addr_t req_addr;
  fcp_pkg::fcp_op_t op_code;
  int               error_cnt, num_checks;

  fcp_bus_if fcp_bus_if_i ();
  fcp_dev_port fcp_dev_port_i (.i_clk(i_clk), .i_nrst(i_nrst), .bus(fcp_bus_if_i), .i_core_ready(core_ready),
    .i_rd_data(rd_data), .o_op_valid(op_valid), .o_op_write(op_write), .o_op_code(op_code),
    .o_op_data(op_data), .o_chipset_mode(dev_chipset_mode));
  fcp_host_port fcp_host_port_i (.i_clk(i_clk), .i_nrst(i_nrst), .bus(fcp_bus_if_i), .i_sys_reset(sys_reset),
    .i_chipset_mode(chipset_mode), .i_sys_ready_n(sys_ready_n), .i_req(req), .i_req_write(req_write),
    .i_req_addr(req_addr), .i_req_be_n(req_be_n), .i_req_wdata(req_wdata), .o_busy(busy), .o_done(done),
    .o_rdata(rdata), .o_select_seen(select_seen), .o_chipset_aux_n(aux_n));
  fcp_bus_checker fcp_bus_checker_i (.i_clk(i_clk), .i_nrst(i_nrst), .bus_reset(fcp_bus_if_i.bus_reset),
    .address_strobe_n(fcp_bus_if_i.address_strobe_n), .mem_io(fcp_bus_if_i.mem_io),
    .write_read(fcp_bus_if_i.write_read), .word_address(fcp_bus_if_i.word_address),
    .host_data_oe(fcp_bus_if_i.host_data_oe), .dev_data_oe(fcp_bus_if_i.dev_data_oe),
    .sys_ready_n(fcp_bus_if_i.sys_ready_n), .dev_ready_n(fcp_bus_if_i.dev_ready_n),
    .dev_ready_oe(fcp_bus_if_i.dev_ready_oe), .ready_n(fcp_bus_if_i.ready_n),
    .copro_select_n(fcp_bus_if_i.copro_select_n), .three_cycle_strap_n(fcp_bus_if_i.three_cycle_strap_n),
    .chipset_aux_out_n(fcp_bus_if_i.chipset_aux_out_n), .chipset_aux_oe(fcp_bus_if_i.chipset_aux_oe));

  // 25 MHz double-rate clock shared by both ends
  always #20 i_clk = ~i_clk;

  // ----------------------------------------------------------------------------
  // access task: one host move, then every outcome compared at the done pulse
  // ----------------------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [2:0] be, input logic [31:0] wd,
                      input logic [31:0] rd, input logic hit, input logic aux_exp);
    logic got_op, aux_seen, owr;
    logic [16:0] code;
    logic [31:0] odata;
    got_op = 1'b0;
    aux_seen = 1'b0;
    owr = 1'b0;
    code = '0;
    odata = '0;
    @(posedge i_clk);
    req <= 1'b1;
    req_write <= wr;
    req_addr <= a[31:2];
    req_be_n <= be;
    req_wdata <= wd;
    rd_data <= rd;
    sys_ready_n <= hit; // misses are answered by other memory so the host never hangs
    @(posedge i_clk);
    req <= 1'b0;
    for (int n = 0; n < 60; n++) begin
      #1;
      if (n == 0) `CHK(busy, 1'b1)
      if (op_valid === 1'b1) begin
        got_op = 1'b1;
        code = op_code;
        odata = op_data;
        owr = op_write;
      end
      if (aux_n === 1'b0) aux_seen = 1'b1;
      if (done === 1'b1) break;
      @(posedge i_clk);
    end
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(got_op, hit)
    `CHK(select_seen, hit)
    `CHK(aux_seen, aux_exp)
    if (hit) begin
      `CHK(code, {a[15:2], be})
      `CHK(owr, wr)
      `CHK(odata, wr ? wd : 32'h0000_0000)
    end
    if (!wr) `CHK(rdata, hit ? rd : 32'hFFFF_FFFF)
    @(posedge i_clk);
    sys_ready_n <= 1'b1;
  endtask

  // strap change only takes effect through a bus reset pulse
  task automatic bus_reset_pulse(input logic chip);
    @(posedge i_clk);
    chipset_mode <= chip;
    sys_reset <= 1'b1;
    repeat (3) @(posedge i_clk);
    sys_reset <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    `CHK(dev_chipset_mode, chip)
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    i_nrst = 1'b0;
    {core_ready, sys_reset, chipset_mode, sys_ready_n, req, req_write} = 6'b100100;
    {rd_data, req_wdata, req_be_n} = '0;
    req_addr = '0;
    error_cnt = 0;
    num_checks = 0;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_clk);
    // window edges, back to back, both directions
    xfer(1'b1, 32'hC000_0000, 3'h0, 32'h1234_5678, 32'h0000_0000, 1'b1, 1'b0);
    xfer(1'b0, 32'hC000_FFFC, 3'h5, 32'h0000_0000, 32'hA5A5_5A5A, 1'b1, 1'b0);
    xfer(1'b1, 32'hC1FF_FFFC, 3'h7, 32'hDEAD_BEEF, 32'h0000_0000, 1'b1, 1'b0);
    xfer(1'b0, 32'hBFFF_FFFC, 3'h1, 32'h0000_0000, 32'h1111_2222, 1'b0, 1'b0);
    xfer(1'b1, 32'hC200_0000, 3'h2, 32'h5555_AAAA, 32'h0000_0000, 1'b0, 1'b0);
    $display("test window done");
    // engine stalls the answer of a read
    @(posedge i_clk);
    core_ready <= 1'b0;
    fork
      xfer(1'b0, 32'hC000_3A48, 3'h2, 32'h0000_0000, 32'h0F0F_F0F0, 1'b1, 1'b0);
      begin
        repeat (8) @(posedge i_clk);
        core_ready <= 1'b1;
      end
    join
    $display("test stall done");
    // three-cycle bus with the aux output, then back to standard
    bus_reset_pulse(1'b1);
    xfer(1'b1, 32'hC000_0104, 3'h3, 32'h0BAD_F00D, 32'h0000_0000, 1'b1, 1'b1);
    xfer(1'b0, 32'hC000_8000, 3'h6, 32'h0000_0000, 32'h8765_4321, 1'b1, 1'b1);
    xfer(1'b0, 32'h4000_0000, 3'h0, 32'h0000_0000, 32'h0000_0001, 1'b0, 1'b0);
    bus_reset_pulse(1'b0);
    xfer(1'b0, 32'hC001_0010, 3'h4, 32'h0000_0000, 32'h3C3C_C3C3, 1'b1, 1'b0);
    $display("test strap done");
    final_report();
  end

  // watchdog: the whole sequence needs about a hundred cycles
  initial begin
    repeat (3000) @(posedge i_clk);
    error_cnt++;
    $display("Error at %0t: run did not finish", $time);
    final_report();
  end
endmodule // tb_fp_coprocessor_host_bus_port
